// File: hw/flash_prot_pkg.sv
// Constants for the flash block-erase and protection controller
// Assumes a single core clock domain and word-wide array access
package flash_prot_pkg;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int FLASH_BYTES = 131072;
    localparam int WORD_BYTES = 4;
    localparam int DEPTH = FLASH_BYTES / WORD_BYTES;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 32;
    localparam int BLOCK_BYTES = 1024;
    localparam int BLOCK_WORDS = BLOCK_BYTES / WORD_BYTES;
    localparam int BLOCK_W = 7;
    localparam int NUM_BLOCKS = FLASH_BYTES / BLOCK_BYTES;
    localparam int NUM_REGIONS = NUM_BLOCKS / 2;
    localparam int REGION_W = 6;
    localparam int WOFF_W = 8;
    localparam int WOFF_LSB = 0;
    localparam int BLOCK_LSB = 8;
    localparam int REGION_LSB = 9;
    localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
    localparam logic [WOFF_W-1:0] LAST_WOFF = 8'hFF;
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_RO = 2'h1;
    localparam logic [1:0] PROT_XO = 2'h2;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_DENY = 2'h1;
    localparam logic [1:0] SRC_FETCH = 2'h0;
    localparam logic [1:0] SRC_DATA = 2'h1;
    localparam logic [1:0] SRC_DEBUG = 2'h2;
endpackage

// File: hw/flash_block_erase_protect.sv
// Flash array with 1 KB block erase and per-2 KB-region protection
// Assumes requesters hold a request until ack; a read and a program can be served in the same cycle
module flash_block_erase_protect
    import flash_prot_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic rd_req,
    input wire logic [1:0] rd_src,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic rd_ack,
    output logic [1:0] rd_resp,
    output logic [DATA_W-1:0] rd_data,
    input wire logic prog_req,
    input wire logic [ADDR_W-1:0] prog_addr,
    input wire logic [DATA_W-1:0] prog_data,
    output logic prog_ack,
    output logic [1:0] prog_resp,
    input wire logic erase_req,
    input wire logic [BLOCK_W-1:0] erase_block,
    output logic erase_busy,
    output logic erase_ack,
    output logic [1:0] erase_resp,
    input wire logic prot_wr,
    input wire logic [REGION_W-1:0] prot_region,
    input wire logic [1:0] prot_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    typedef enum logic [1:0] {IDLE, ERASING, DONE} erase_state_e;

    // Region of a word address
    function automatic logic [REGION_W-1:0] region_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:REGION_LSB];
    endfunction

    logic [DATA_W-1:0] mem [DEPTH];
    logic [1:0] prot_reg [NUM_REGIONS];
    logic [1:0] prot_next [NUM_REGIONS];
    erase_state_e state_reg, state_next;
    logic [BLOCK_W-1:0] blk_reg, blk_next;
    logic [WOFF_W-1:0] woff_reg, woff_next;
    logic rd_ack_reg, rd_ack_next;
    logic [1:0] rd_resp_reg, rd_resp_next;
    logic [DATA_W-1:0] rd_data_reg, rd_data_next;
    logic prog_ack_reg, prog_ack_next;
    logic [1:0] prog_resp_reg, prog_resp_next;
    logic erase_ack_reg, erase_ack_next;
    logic [1:0] erase_resp_reg, erase_resp_next;
    logic [1:0] rd_prot, pg_prot, er_prot;
    logic rd_ok, pg_ok, er_ok, pg_do, er_wr;
    logic [ADDR_W-1:0] er_addr;

    // Protection lookups per request
    assign rd_prot = prot_reg[region_of(rd_addr)];
    assign pg_prot = prot_reg[region_of(prog_addr)];
    assign er_prot = prot_reg[erase_block[BLOCK_W-1:1]];
    assign rd_ok = (rd_prot != PROT_XO) || (rd_src == SRC_FETCH);
    assign pg_ok = (pg_prot == PROT_NONE);
    assign er_ok = (er_prot == PROT_NONE);
    assign pg_do = prog_req && !prog_ack_reg && !erase_busy && pg_ok;
    assign er_wr = (state_reg == ERASING);
    assign er_addr = {blk_reg, woff_reg};

    // Protection setting updates, one region each
    generate
        for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_prot
            always_comb begin
                prot_next[g] = prot_reg[g];
                if (prot_wr && (prot_region == REGION_W'(g))) begin
                    prot_next[g] = prot_mode;
                end
            end
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    prot_reg[g] <= PROT_NONE;
                end else begin
                    prot_reg[g] <= prot_next[g];
                end
            end
        end
    endgenerate

    // Erase sequencer and request answers
    always_comb begin
        state_next = state_reg;
        blk_next = blk_reg;
        woff_next = woff_reg;
        erase_ack_next = 1'b0;
        erase_resp_next = erase_resp_reg;
        rd_ack_next = 1'b0;
        rd_resp_next = rd_resp_reg;
        rd_data_next = rd_data_reg;
        prog_ack_next = 1'b0;
        prog_resp_next = prog_resp_reg;
        unique case (state_reg)
            IDLE: begin
                if (erase_req) begin
                    if (er_ok) begin
                        state_next = ERASING;
                        blk_next = erase_block;
                        woff_next = '0;
                    end else begin
                        erase_ack_next = 1'b1;
                        erase_resp_next = RESP_DENY;
                    end
                end
            end
            ERASING: begin
                woff_next = woff_reg + 1'b1;
                if (woff_reg == LAST_WOFF) begin
                    state_next = DONE;
                end
            end
            DONE: begin
                state_next = IDLE;
                erase_ack_next = 1'b1;
                erase_resp_next = RESP_OK;
            end
        endcase
        if (erase_ack_reg) begin
            erase_ack_next = 1'b0;
            if (state_reg == IDLE) begin
                state_next = IDLE;
            end
        end
        if (rd_req && !rd_ack_reg && !erase_busy) begin
            rd_ack_next = 1'b1;
            rd_resp_next = rd_ok ? RESP_OK : RESP_DENY;
            rd_data_next = rd_ok ? mem[rd_addr] : '0;
        end
        if (prog_req && !prog_ack_reg && !erase_busy) begin
            prog_ack_next = 1'b1;
            prog_resp_next = pg_ok ? RESP_OK : RESP_DENY;
        end
    end

    // Registers of the sequencer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= IDLE;
            blk_reg <= '0;
            woff_reg <= '0;
            erase_ack_reg <= 1'b0;
            erase_resp_reg <= RESP_OK;
            rd_ack_reg <= 1'b0;
            rd_resp_reg <= RESP_OK;
            rd_data_reg <= '0;
            prog_ack_reg <= 1'b0;
            prog_resp_reg <= RESP_OK;
        end else begin
            state_reg <= state_next;
            blk_reg <= blk_next;
            woff_reg <= woff_next;
            erase_ack_reg <= erase_ack_next;
            erase_resp_reg <= erase_resp_next;
            rd_ack_reg <= rd_ack_next;
            rd_resp_reg <= rd_resp_next;
            rd_data_reg <= rd_data_next;
            prog_ack_reg <= prog_ack_next;
            prog_resp_reg <= prog_resp_next;
        end
    end

    // Array writes: erase fill or program, never both
    always_ff @(posedge core_clk) begin
        if (er_wr) begin
            mem[er_addr] <= ERASED_WORD;
        end else if (pg_do) begin
            mem[prog_addr] <= mem[prog_addr] & prog_data;
        end
    end

    assign erase_busy = (state_reg != IDLE);
    assign rd_ack = rd_ack_reg;
    assign rd_resp = rd_resp_reg;
    assign rd_data = rd_data_reg;
    assign prog_ack = prog_ack_reg;
    assign prog_resp = prog_resp_reg;
    assign erase_ack = erase_ack_reg;
    assign erase_resp = erase_resp_reg;

    // Checks
    erase_runs_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == IDLE && erase_req && er_ok && !erase_ack_reg) |=> erase_busy [*8])
        else $error("erase did not run");
    erase_done_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == ERASING && woff_reg == LAST_WOFF) |=> ##1 (erase_ack && erase_resp == RESP_OK))
        else $error("erase finish not acknowledged");
    erase_fill_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        er_wr |-> ##1 (mem[$past(er_addr)] == ERASED_WORD))
        else $error("erased word not all ones");
    erase_deny_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == IDLE && erase_req && !erase_ack_reg && er_prot != PROT_NONE)
        |=> (erase_ack && erase_resp == RESP_DENY && !erase_busy))
        else $error("protected erase not refused");
    prog_deny_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (prog_req && !prog_ack_reg && !erase_busy && pg_prot != PROT_NONE)
        |=> (prog_ack && prog_resp == RESP_DENY))
        else $error("protected program not refused");
    xo_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (rd_req && !rd_ack_reg && !erase_busy && rd_prot == PROT_XO && rd_src != SRC_FETCH)
        |=> (rd_ack && rd_resp == RESP_DENY && rd_data == '0))
        else $error("execute-only read not denied");
    ro_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (rd_req && !rd_ack_reg && !erase_busy && rd_prot == PROT_RO)
        |=> (rd_ack && rd_resp == RESP_OK))
        else $error("read-only read refused");
    prot_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        prot_wr |=> (prot_reg[$past(prot_region)] == $past(prot_mode)))
        else $error("protection setting not stored");
    prog_grant_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        pg_do |=> (prog_ack && prog_resp == RESP_OK))
        else $error("permitted program not accepted");
    erase_stall_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_reg == ERASING) |=> (!rd_ack && !prog_ack))
        else $error("access served during erase");
endmodule

// File: test/flash_requester.sv
// Requester model for the fetch, data-bus and debugger side of the flash controller
// Assumes a free-running core_clk; requests change only at the falling edge
module flash_requester
    import flash_prot_pkg::*;
(
    input wire logic core_clk,
    input wire logic rd_ack,
    input wire logic [1:0] rd_resp,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic prog_ack,
    input wire logic [1:0] prog_resp,
    input wire logic erase_ack,
    input wire logic [1:0] erase_resp,
    output logic rd_req,
    output logic [1:0] rd_src,
    output logic [ADDR_W-1:0] rd_addr,
    output logic prog_req,
    output logic [ADDR_W-1:0] prog_addr,
    output logic [DATA_W-1:0] prog_data,
    output logic erase_req,
    output logic [BLOCK_W-1:0] erase_block,
    output logic prot_wr,
    output logic [REGION_W-1:0] prot_region,
    output logic [1:0] prot_mode
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus at time zero
    initial begin
        {rd_req, prog_req, erase_req, prot_wr} = 4'h0;
        {rd_src, rd_addr, prog_addr, prog_data, erase_block, prot_region, prot_mode} = '0;
    end
    // Read: hold until ack, then scramble the released lines
    task automatic rd(input logic [1:0] s, input logic [ADDR_W-1:0] a, output logic [1:0] r,
        output logic [DATA_W-1:0] d, output int n);
        @(negedge core_clk);
        {rd_src, rd_addr, rd_req} = {s, a, 1'b1};
        n = 0;
        do begin @(negedge core_clk); n++; end while (rd_ack !== 1'b1 && n < 400);
        {r, d} = {rd_resp, rd_data};
        {rd_src, rd_addr, rd_req} = {~s, ~a, 1'b0};
    endtask
    // Program: same handshake as a read
    task automatic pg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v, output logic [1:0] r,
        output int n);
        @(negedge core_clk);
        {prog_addr, prog_data, prog_req} = {a, v, 1'b1};
        n = 0;
        do begin @(negedge core_clk); n++; end while (prog_ack !== 1'b1 && n < 400);
        r = prog_resp;
        {prog_addr, prog_data, prog_req} = {~a, ~v, 1'b0};
    endtask
    // Erase: request dropped at the ack
    task automatic er(input logic [BLOCK_W-1:0] b, output logic [1:0] r, output int n);
        @(negedge core_clk);
        {erase_block, erase_req} = {b, 1'b1};
        n = 0;
        do begin @(negedge core_clk); n++; end while (erase_ack !== 1'b1 && n < 400);
        r = erase_resp;
        {erase_block, erase_req} = {~b, 1'b0};
    endtask
    // Protection write: one-cycle strobe
    task automatic setp(input logic [REGION_W-1:0] g, input logic [1:0] m);
        @(negedge core_clk);
        {prot_region, prot_mode, prot_wr} = {g, m, 1'b1};
        @(negedge core_clk);
        {prot_region, prot_mode, prot_wr} = {~g, ~m, 1'b0};
    endtask
endmodule

// File: test/flash_block_erase_protect_test.sv
// Self-checking bench for the flash erase and protection controller
// Assumes the requester model drives every request input
module flash_block_erase_protect_test;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_prot_pkg::*;
    logic core_clk, sys_rst, rd_req, prog_req, erase_req, prot_wr, rd_ack, prog_ack, erase_busy, erase_ack;
    logic [1:0] rd_src, rd_resp, prog_resp, erase_resp, prot_mode;
    logic [ADDR_W-1:0] rd_addr, prog_addr;
    logic [DATA_W-1:0] rd_data, prog_data, v, w;
    logic [BLOCK_W-1:0] erase_block, b;
    logic [REGION_W-1:0] prot_region, g;
    int n_mismatch = 0;
    int tests_run = 0;
    flash_block_erase_protect flash_block_erase_protect_i (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .rd_req(rd_req),
        .rd_src(rd_src),
        .rd_addr(rd_addr),
        .rd_ack(rd_ack),
        .rd_resp(rd_resp),
        .rd_data(rd_data),
        .prog_req(prog_req),
        .prog_addr(prog_addr),
        .prog_data(prog_data),
        .prog_ack(prog_ack),
        .prog_resp(prog_resp),
        .erase_req(erase_req),
        .erase_block(erase_block),
        .erase_busy(erase_busy),
        .erase_ack(erase_ack),
        .erase_resp(erase_resp),
        .prot_wr(prot_wr),
        .prot_region(prot_region),
        .prot_mode(prot_mode)
    );
    flash_requester flash_requester_i (
        .core_clk(core_clk),
        .rd_ack(rd_ack),
        .rd_resp(rd_resp),
        .rd_data(rd_data),
        .prog_ack(prog_ack),
        .prog_resp(prog_resp),
        .erase_ack(erase_ack),
        .erase_resp(erase_resp),
        .rd_req(rd_req),
        .rd_src(rd_src),
        .rd_addr(rd_addr),
        .prog_req(prog_req),
        .prog_addr(prog_addr),
        .prog_data(prog_data),
        .erase_req(erase_req),
        .erase_block(erase_block),
        .prot_wr(prot_wr),
        .prot_region(prot_region),
        .prot_mode(prot_mode)
    );
    // Clock at 40 MHz
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin n_mismatch++; $display("mismatch at %0t: %s", $time, m); end
    endtask
    task automatic wrap_up();
        $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Bus wrappers comparing answer code and latency, plus data for reads
    task automatic rdc(input logic [1:0] s, input logic [ADDR_W-1:0] a, input logic [1:0] er,
        input logic [DATA_W-1:0] ed);
        logic [1:0] r; logic [DATA_W-1:0] d; int n;
        flash_requester_i.rd(s, a, r, d, n);
        chk(r === er && d === ed && n <= 2, "read answer");
    endtask
    task automatic pgc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x, input logic [1:0] er);
        logic [1:0] r; int n;
        flash_requester_i.pg(a, x, r, n);
        chk(r === er && n <= 2, "program answer");
    endtask
    task automatic erc(input logic [BLOCK_W-1:0] k, input logic [1:0] er);
        logic [1:0] r; int n;
        flash_requester_i.er(k, r, n);
        chk(r === er && (er == RESP_OK ? (n >= 257 && n <= 260) : n <= 3), "erase answer");
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (30000) @(posedge core_clk);
        n_mismatch++;
        wrap_up();
    end
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        void'($urandom(44));
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        chk(rd_ack === 1'b0 && erase_busy === 1'b0 && rd_data === 32'h00000000, "reset outputs");
        // Block erase at both ends of the array and at random places
        for (int i = 0; i < 4; i++) begin
            b = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom_range(1, 126));
            v = $urandom;
            w = $urandom;
            erc(b ^ 7'h01, RESP_OK);
            pgc({b ^ 7'h01, 8'h33}, v, RESP_OK);
            pgc({b ^ 7'h01, 8'h33}, w, RESP_OK);
            pgc({b, 8'h05}, 32'h00000000, RESP_OK);
            erc(b, RESP_OK);
            rdc(SRC_DATA, {b, 8'h00}, RESP_OK, ERASED_WORD);
            rdc(SRC_DEBUG, {b, 8'h05}, RESP_OK, ERASED_WORD);
            rdc(SRC_FETCH, {b, LAST_WOFF}, RESP_OK, ERASED_WORD);
            rdc(SRC_DATA, {b ^ 7'h01, 8'h33}, RESP_OK, v & w);
        end
        // Every protection mode against both blocks and all requesters
        for (int m = 1; m < 4; m++) begin
            g = 6'($urandom_range(0, 62));
            v = $urandom;
            erc({g, 1'b0}, RESP_OK);
            erc({g, 1'b1}, RESP_OK);
            pgc({g, 1'b1, 8'h10}, v, RESP_OK);
            flash_requester_i.setp(g, 2'(m));
            erc({g, 1'b0}, RESP_DENY);
            erc({g, 1'b1}, RESP_DENY);
            pgc({g, 1'b0, 8'h10}, 32'h00000000, RESP_DENY);
            for (int s = 0; s < 3; s++)
                rdc(2'(s), {g, 1'b1, 8'h10}, (m == 2 && s != 0) ? RESP_DENY : RESP_OK, (m == 2 && s != 0) ? '0 : v);
            rdc(SRC_FETCH, {g, 1'b0, 8'h10}, RESP_OK, ERASED_WORD);
            erc({6'(g + 6'h01), 1'b1}, RESP_OK);
            flash_requester_i.setp(g, PROT_NONE);
            erc({g, 1'b1}, RESP_OK);
        end
        // Reset in mid-run leaves every region unprotected
        g = 6'($urandom_range(0, 63));
        flash_requester_i.setp(g, PROT_RO);
        @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        chk(rd_ack === 1'b0 && prog_ack === 1'b0 && erase_ack === 1'b0 && erase_busy === 1'b0, "reset outputs");
        erc({g, 1'b0}, RESP_OK);
        pgc({g, 1'b1, 8'h20}, 32'h00000000, RESP_OK);
        wrap_up();
    end
endmodule
